//--- common/icc_pkg.sv
package icc_pkg;

    // Register addresses (byte writes, word read at the base)
    localparam logic [7:0] ADDR_CFG_B0 = 8'h0C;
    localparam logic [7:0] ADDR_CFG_B1 = 8'h0D;
    localparam logic [7:0] ADDR_CFG_B2 = 8'h0E;
    localparam logic [7:0] ADDR_CFG_B3 = 8'h0F;

    // Field positions
    localparam int POS_FILTER   = 30;
    localparam int POS_KEEP_OFF = 29;
    localparam int POS_KEEP_GN  = 28;
    localparam int POS_KEEP_OUT = 27;
    localparam int POS_KEEP_SPD = 26;
    localparam int POS_KEEP_ADC = 25;
    localparam int POS_KEEP_VEC = 24;
    localparam int POS_IND_MODE = 23;
    localparam int POS_HOLD     = 22;
    localparam int POS_DET_OFF  = 21;
    localparam int POS_DET_GN   = 20;
    localparam int POS_SQ_MODE  = 19;
    localparam int POS_DET_SPD  = 18;
    localparam int POS_DET_ADC  = 17;
    localparam int POS_DET_VEC  = 16;
    localparam int POS_AMP_LO   = 14;
    localparam int POS_TRG_EDGE = 13;
    localparam int POS_HYST     = 12;

    // Reset value of fixed bits; bits 15-14 and 12 come from strap pins
    localparam logic [31:0] CFG_RESET = 32'h007F_0000;

    // Fill count at which boot ends (three cycles) so the strap synchronisers hold pin levels
    localparam logic [1:0] FILL_CYCLES = 2'h2;

    // Error status layout (nine bits, 8 down to 0, of the status word)
    localparam int ERR_S_OFF = 8;
    localparam int ERR_C_OFF = 7;
    localparam int ERR_S_GN  = 6;
    localparam int ERR_C_GN  = 5;
    localparam int ERR_OUT   = 4;
    localparam int ERR_SPD   = 3;
    localparam int ERR_S_ADC = 2;
    localparam int ERR_C_ADC = 1;
    localparam int ERR_VEC   = 0;
    localparam int NUM_ERR   = 9;

    typedef enum logic [2:0] {
        ICC_BOOT = 3'b001,
        ICC_LOAD = 3'b010,
        ICC_RUN  = 3'b100
    } icc_phase_t;

    // Host write strobe with its byte
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } icc_wr_t;

    typedef struct packed {
        icc_phase_t          phase;
        logic [1:0]          fill;
        logic [31:0]         cfg;
        logic [NUM_ERR-1:0]  err;
        logic [2:0]          amp0_sync;
        logic [2:0]          amp1_sync;
        logic [2:0]          filt_sync;
        logic [2:0]          trg_sync;
        logic                trg_level;
        logic                capture;
    } icc_state_t;

endpackage

//--- hdl/icc_config.sv
`timescale 1ns/1ps

module icc_config (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    // Host register port
    input  wire icc_pkg::icc_wr_t       host_wr,
    input  wire logic                   host_rd,
    output logic [31:0]                 rd_data,
    output logic                        rd_valid,
    input  wire logic                   clear_count_command,
    input  wire logic                   clear_index_command,
    input  wire logic                   rate_changed,
    // Strap pins
    input  wire logic [1:0]             amplitude_strap_pin,
    input  wire logic                   filter_strap_pin,
    // Trigger pin
    input  wire logic                   capture_trigger_pin,
    // Live error conditions from the datapath
    input  wire logic [8:0]             live_errors,
    input  wire logic                   index_event,
    // Datapath controls
    output logic                        noise_filter_enable,
    output logic                        indicator_pin_mode,
    output logic                        hold_outputs_on_error,
    output logic                        square_wave_mode_select,
    output logic [1:0]                  amplitude_range_select,
    output logic                        hysteresis_enable,
    output logic                        capture_strobe,
    output logic                        clear_position,
    // Status
    output logic [8:0]                  error_status,
    output logic                        index_status_bit
);

    icc_pkg::icc_state_t st;
    icc_pkg::icc_state_t next_st;
    logic                idx;
    logic                next_idx;
    logic [31:0]         rdq;
    logic                rdv;

    logic [8:0] detect_en;
    logic [8:0] keep_en;
    logic [8:0] live_gated;

    // Map each status flag to its detect and keep bits; the output flag uses the square-wave mode bit as its detect bit
    always_comb begin
        detect_en = '0;
        keep_en   = '0;
        detect_en[icc_pkg::ERR_S_OFF] = st.cfg[icc_pkg::POS_DET_OFF];
        detect_en[icc_pkg::ERR_C_OFF] = st.cfg[icc_pkg::POS_DET_OFF];
        detect_en[icc_pkg::ERR_S_GN]  = st.cfg[icc_pkg::POS_DET_GN];
        detect_en[icc_pkg::ERR_C_GN]  = st.cfg[icc_pkg::POS_DET_GN];
        detect_en[icc_pkg::ERR_OUT]   = st.cfg[icc_pkg::POS_SQ_MODE];
        detect_en[icc_pkg::ERR_SPD]   = st.cfg[icc_pkg::POS_DET_SPD];
        detect_en[icc_pkg::ERR_S_ADC] = st.cfg[icc_pkg::POS_DET_ADC];
        detect_en[icc_pkg::ERR_C_ADC] = st.cfg[icc_pkg::POS_DET_ADC];
        detect_en[icc_pkg::ERR_VEC]   = st.cfg[icc_pkg::POS_DET_VEC];
        keep_en[icc_pkg::ERR_S_OFF]   = st.cfg[icc_pkg::POS_KEEP_OFF];
        keep_en[icc_pkg::ERR_C_OFF]   = st.cfg[icc_pkg::POS_KEEP_OFF];
        keep_en[icc_pkg::ERR_S_GN]    = st.cfg[icc_pkg::POS_KEEP_GN];
        keep_en[icc_pkg::ERR_C_GN]    = st.cfg[icc_pkg::POS_KEEP_GN];
        keep_en[icc_pkg::ERR_OUT]     = st.cfg[icc_pkg::POS_KEEP_OUT];
        keep_en[icc_pkg::ERR_SPD]     = st.cfg[icc_pkg::POS_KEEP_SPD];
        keep_en[icc_pkg::ERR_S_ADC]   = st.cfg[icc_pkg::POS_KEEP_ADC];
        keep_en[icc_pkg::ERR_C_ADC]   = st.cfg[icc_pkg::POS_KEEP_ADC];
        keep_en[icc_pkg::ERR_VEC]     = st.cfg[icc_pkg::POS_KEEP_VEC];
    end

    // A rate change counts as an output error only in square-wave mode
    always_comb begin
        live_gated = live_errors;
        live_gated[icc_pkg::ERR_OUT] = live_errors[icc_pkg::ERR_OUT] | rate_changed;
        live_gated = live_gated & detect_en;
    end

    always_comb begin
        next_st = st;
        next_idx = idx;
        next_st.amp0_sync = {st.amp0_sync[1:0], amplitude_strap_pin[0]};
        next_st.amp1_sync = {st.amp1_sync[1:0], amplitude_strap_pin[1]};
        next_st.filt_sync = {st.filt_sync[1:0], filter_strap_pin};
        next_st.trg_sync  = {st.trg_sync[1:0], capture_trigger_pin};
        next_st.capture   = 1'b0;

        // Trigger level settles once stages two and three agree
        if (st.trg_sync[1] == st.trg_sync[2]) begin
            next_st.trg_level = st.trg_sync[2];
            if (st.phase == icc_pkg::ICC_RUN && st.trg_sync[2] != st.trg_level) begin
                next_st.capture = (st.trg_sync[2] == st.cfg[icc_pkg::POS_TRG_EDGE]);
            end
        end

        case (st.phase)
            // Wait for the strap synchronisers to fill before sampling them
            icc_pkg::ICC_BOOT: begin
                next_st.fill = 2'(st.fill + 2'h1);
                if (st.fill == icc_pkg::FILL_CYCLES) begin
                    next_st.phase = icc_pkg::ICC_LOAD;
                end
            end
            icc_pkg::ICC_LOAD: begin
                if (st.amp0_sync[2] == st.amp0_sync[1] && st.amp1_sync[2] == st.amp1_sync[1]
                    && st.filt_sync[2] == st.filt_sync[1]) begin
                    next_st.cfg[icc_pkg::POS_AMP_LO +: 2] =
                        {st.amp1_sync[2], st.amp0_sync[2]};
                    next_st.cfg[icc_pkg::POS_HYST] = st.filt_sync[2];
                    next_st.trg_level = st.trg_sync[2];
                    next_st.phase = icc_pkg::ICC_RUN;
                end
            end
            icc_pkg::ICC_RUN: begin
                if (host_wr.wr) begin
                    if (host_wr.addr == icc_pkg::ADDR_CFG_B0) begin
                        next_st.cfg[7:0] = host_wr.data;
                    end else if (host_wr.addr == icc_pkg::ADDR_CFG_B1) begin
                        next_st.cfg[15:8] = host_wr.data;
                    end else if (host_wr.addr == icc_pkg::ADDR_CFG_B2) begin
                        next_st.cfg[23:16] = host_wr.data;
                    end else if (host_wr.addr == icc_pkg::ADDR_CFG_B3) begin
                        next_st.cfg[31:24] = host_wr.data;
                    end
                end
            end
            default: begin
                next_st.phase = icc_pkg::ICC_BOOT;
            end
        endcase

        // Sticky flags clear on the command, but a new event wins the same cycle
        for (int i = 0; i < icc_pkg::NUM_ERR; i++) begin
            if (keep_en[i]) begin
                next_st.err[i] = (st.err[i] & ~clear_count_command) | live_gated[i];
            end else begin
                next_st.err[i] = live_gated[i];
            end
            if (!detect_en[i]) begin
                next_st.err[i] = 1'b0;
            end
        end

        next_idx = (idx & ~clear_count_command & ~clear_index_command) | index_event;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st.phase     <= icc_pkg::ICC_BOOT;
            st.fill      <= 2'h0;
            st.cfg       <= icc_pkg::CFG_RESET;
            st.err       <= '0;
            st.amp0_sync <= '0;
            st.amp1_sync <= '0;
            st.filt_sync <= '0;
            st.trg_sync  <= '0;
            st.trg_level <= 1'b0;
            st.capture   <= 1'b0;
            idx          <= 1'b0;
            rdq          <= '0;
            rdv          <= 1'b0;
        end else begin
            st  <= next_st;
            idx <= next_idx;
            rdv <= host_rd;
            if (host_rd) begin
                rdq <= st.cfg;
            end
        end
    end

    assign rd_data                 = rdq;
    assign rd_valid                = rdv;
    assign noise_filter_enable     = st.cfg[icc_pkg::POS_FILTER];
    assign indicator_pin_mode      = st.cfg[icc_pkg::POS_IND_MODE];
    assign hold_outputs_on_error   = st.cfg[icc_pkg::POS_HOLD];
    assign square_wave_mode_select = st.cfg[icc_pkg::POS_SQ_MODE];
    assign amplitude_range_select  = st.cfg[icc_pkg::POS_AMP_LO +: 2];
    assign hysteresis_enable       = st.cfg[icc_pkg::POS_HYST];
    assign capture_strobe          = st.capture;
    assign clear_position          = clear_count_command;
    assign error_status            = st.err;
    assign index_status_bit        = idx;

endmodule

//--- dv/icc_config_chk.sv
`timescale 1ns/1ps
module icc_config_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Host side
    input wire logic        host_rd,
    input wire logic [31:0] rd_data,
    input wire logic        rd_valid,
    input wire logic        clear_count_command,
    input wire logic        rate_changed,
    // Datapath side
    input wire logic [8:0]  live_errors,
    input wire logic        index_event,
    input wire logic        noise_filter_enable,
    input wire logic        square_wave_mode_select,
    input wire logic        capture_strobe,
    input wire logic        clear_position,
    input wire logic [8:0]  error_status,
    input wire logic        index_status_bit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    chk_read_answer: assert property (
        host_rd |=> rd_valid) else $error("read not answered");
    chk_read_hold: assert property (
        !host_rd |=> $stable(rd_data)) else $error("read data moved");
    chk_read_word: assert property (
        rd_valid |-> rd_data[30] == $past(noise_filter_enable)
        && rd_data[19] == $past(square_wave_mode_select)) else $error("word mismatch");
    chk_clear_pos: assert property (
        clear_position == clear_count_command) else $error("clear not passed");
    chk_clear_flags: assert property (
        clear_count_command && live_errors == 9'h000 && !rate_changed && !index_event
        |=> error_status == 9'h000 && !index_status_bit) else $error("flags kept");
    chk_counter_mode: assert property (
        !square_wave_mode_select && !error_status[4] |=> !error_status[4])
        else $error("output error in counter mode");
    chk_set_wins: assert property (
        square_wave_mode_select && (live_errors[4] || rate_changed) |=> error_status[4])
        else $error("output error missed");
    chk_strobe_pulse: assert property (
        capture_strobe |=> !capture_strobe) else $error("strobe too long");
endmodule
bind icc_config icc_config_chk icc_config_chk_inst (.*);

//--- dv/icc_host.sv
`timescale 1ns/1ps
module icc_host (
    // Clock
    input wire logic         mclk,
    // Register port
    output icc_pkg::icc_wr_t host_wr,
    output logic             host_rd,
    input wire logic [31:0]  rd_data
);
    initial begin
        host_wr = '0;
        host_rd = 1'b0;
    end
    // Idle bus shows inverted values so stale bytes never look valid
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        host_wr <= '{1'b1, a, d};
        @(posedge mclk);
        host_wr <= '{1'b0, ~a, ~d};
    endtask
    task automatic rd_word(output logic [31:0] w);
        @(posedge mclk);
        host_rd <= 1'b1;
        @(posedge mclk);
        host_rd <= 1'b0;
        @(negedge mclk);
        w = rd_data;
    endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic             mclk, nrst, host_rd, rd_valid, clear_count_command;
    logic             clear_index_command, rate_changed, filter_strap_pin;
    logic             capture_trigger_pin, index_event, noise_filter_enable;
    logic             indicator_pin_mode, hold_outputs_on_error, square_wave_mode_select;
    logic             hysteresis_enable, capture_strobe, clear_position, index_status_bit;
    logic [1:0]       amplitude_strap_pin, amplitude_range_select;
    logic [8:0]       live_errors, error_status;
    logic [31:0]      rd_data, got;
    icc_pkg::icc_wr_t host_wr;
    int               err_total, num_checks, n;
    typedef struct {logic [7:0] a, d; logic [31:0] w;} icc_row_t;
    icc_row_t         rows[8] = '{
        '{8'h0F, 8'h40, 32'h407F_9000}, '{8'h0E, 8'h00, 32'h4000_9000},
        '{8'h0D, 8'hE5, 32'h4000_E500}, '{8'h0C, 8'hA5, 32'h4000_E5A5},
        '{8'h0F, 8'h3F, 32'h3F00_E5A5}, '{8'h0E, 8'hFF, 32'h3FFF_E5A5},
        '{8'h10, 8'h55, 32'h3FFF_E5A5}, '{8'h0B, 8'h00, 32'h3FFF_E5A5}};

    icc_config icc_config_inst (.*);
    icc_host   icc_host_inst (.*);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk_cfg(input logic [31:0] e);
        icc_host_inst.rd_word(got);
        cmp(got, e);
        cmp(32'({noise_filter_enable, indicator_pin_mode, hold_outputs_on_error,
            square_wave_mode_select, amplitude_range_select, hysteresis_enable}),
            32'({e[30], e[23:22], e[19], e[15:14], e[12]}));
    endtask
    // Flags seen just after the pulse and one cycle later
    task automatic pulse_err(input logic [8:0] l, input logic r, input logic [8:0] e1, e2);
        @(posedge mclk);
        live_errors <= l;
        rate_changed <= r;
        @(posedge mclk);
        live_errors <= 9'h000;
        rate_changed <= 1'b0;
        @(negedge mclk);
        cmp(32'(error_status), 32'(e1));
        @(negedge mclk);
        cmp(32'(error_status), 32'(e2));
    endtask
    task automatic trig(input logic v, input int k);
        @(posedge mclk);
        capture_trigger_pin <= v;
        n = 0;
        repeat (8) begin
            @(negedge mclk);
            if (capture_strobe === 1'b1) n++;
        end
        cmp(n, k);
    endtask
    task automatic do_reset(input logic [1:0] a, input logic f);
        @(posedge mclk);
        nrst <= 1'b0;
        amplitude_strap_pin <= a;
        filter_strap_pin <= f;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        {nrst, clear_count_command, clear_index_command, rate_changed} = '0;
        {capture_trigger_pin, index_event, live_errors} = '0;
        {amplitude_strap_pin, filter_strap_pin} = 3'b101;
        err_total = 0;
        num_checks = 0;
        do_reset(2'b10, 1'b1);
        chk_cfg(32'h007F_9000);
        foreach (rows[i]) begin
            icc_host_inst.wr_byte(rows[i].a, rows[i].d);
            chk_cfg(rows[i].w);
        end
        $display("test table ended");
        pulse_err(9'h1FF, 1'b0, 9'h1FF, 9'h1FF);
        @(posedge mclk);
        index_event <= 1'b1;
        @(posedge mclk);
        index_event <= 1'b0;
        clear_count_command <= 1'b1;
        @(negedge mclk);
        cmp(32'(index_status_bit), 32'h1);
        @(posedge mclk);
        clear_count_command <= 1'b0;
        @(negedge mclk);
        cmp(32'({index_status_bit, error_status}), 32'h0);
        @(posedge mclk);
        index_event <= 1'b1;
        @(posedge mclk);
        index_event <= 1'b0;
        clear_index_command <= 1'b1;
        @(posedge mclk);
        clear_index_command <= 1'b0;
        @(negedge mclk);
        cmp(32'(index_status_bit), 32'h0);
        icc_host_inst.wr_byte(8'h0F, 8'h00);
        pulse_err(9'h155, 1'b0, 9'h155, 9'h000);
        icc_host_inst.wr_byte(8'h0E, 8'h00);
        pulse_err(9'h1FF, 1'b1, 9'h000, 9'h000);
        icc_host_inst.wr_byte(8'h0E, 8'h08);
        pulse_err(9'h000, 1'b1, 9'h010, 9'h000);
        $display("test errors ended");
        trig(1'b1, 1);
        trig(1'b0, 0);
        icc_host_inst.wr_byte(8'h0D, 8'hC5);
        trig(1'b1, 0);
        trig(1'b0, 1);
        $display("test trigger ended");
        do_reset(2'b01, 1'b0);
        chk_cfg(32'h007F_4000);
        $display("test reset ended");
        test_done;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        err_total++;
        $display("unexpected at %0t: timeout", $time);
        test_done;
    end
endmodule
